/* flash_host_pkg.sv */
package flash_host_pkg;
   // register offsets of the command port
   localparam logic [3:0] REG_CTRL   = 4'h0;
   localparam logic [3:0] REG_ADDR   = 4'h1;
   localparam logic [3:0] REG_WDATA  = 4'h2;
   localparam logic [3:0] REG_RDATA  = 4'h3;
   localparam logic [3:0] REG_STATUS = 4'h4;
   // control bit positions
   localparam int CTRL_GO_READ  = 0;
   localparam int CTRL_GO_WRITE = 1;
   localparam int CTRL_GO_RESET = 2;
   localparam int CTRL_WORD     = 3;
   localparam int CTRL_ID_MODE  = 4;
   localparam int CTRL_TEMP_UNP = 5;
   // timing in nanoseconds and clock rate
   localparam int CLK_NS          = 100;
   localparam int ACCESS_NS       = 100;
   localparam int WRITE_PULSE_NS  = 100;
   localparam int RESET_PULSE_NS  = 500;
   localparam int READY_RECOV_NS  = 100;
   localparam int RESET_RECOV_NS  = 100;
   localparam logic [7:0] ACCESS_CYC =
      8'((ACCESS_NS + CLK_NS - 1) / CLK_NS + 1);
   localparam logic [7:0] WRITE_CYC =
      8'((WRITE_PULSE_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [7:0] RESET_CYC =
      8'((RESET_PULSE_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [7:0] READY_RECOV_CYC =
      8'((READY_RECOV_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [7:0] RESET_RECOV_CYC =
      8'((RESET_RECOV_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [15:0] DATA_RESET = 16'h0000;
   localparam logic [19:0] ADDR_RESET = 20'h0_0000;
endpackage

/* flash_host.sv */
module flash_host
   import flash_host_pkg::*;
(
   input  wire logic        clk_i,          // 10 mhz clock
   input  wire logic        reset_n_i,      // async reset, active low
   input  wire logic [3:0]  reg_addr_i,     // register address
   input  wire logic [19:0] reg_wdata_i,    // register write data
   input  wire logic        reg_wr_i,       // write strobe
   input  wire logic        reg_rd_i,       // read strobe
   output logic      [19:0] reg_rdata_o,    // read data, next cycle
   output logic      [18:0] flash_addr_o,   // address pins
   output logic      [15:0] flash_dq_o,     // data pins, out
   output logic      [15:0] flash_dq_oe_n_o,// data pin enable, low drives
   input  wire logic [15:0] flash_dq_i,     // data pins, in
   output logic             flash_ce_n_o,   // chip select
   output logic             flash_oe_n_o,   // output gate
   output logic             flash_we_n_o,   // write strobe
   output logic             flash_rst_n_o,  // reset pin
   output logic             flash_byte_n_o, // width select, high word
   output logic             a9_hv_o,        // elevated voltage on a9
   output logic             rst_hv_o,       // elevated voltage on reset pin
   input  wire logic        ready_busy_out_i// device ready, high
);
   import flash_host_pkg::*;

   typedef enum logic [2:0] {
      ST_IDLE, ST_READ, ST_WRITE, ST_WREC, ST_RST, ST_WAIT_RDY, ST_RECOV
   } state_e;

   state_e      state_q, state_d;
   logic [7:0]  cnt_q, cnt_d;
   logic [19:0] addr_q;
   logic [15:0] wdata_q, rdata_q;
   logic [5:0]  ctrl_q;
   logic        busy_at_rst_q;
   logic        timeout_q;
   logic        done_q;

   // command decode
   wire wr_ctrl  = reg_wr_i && (reg_addr_i == REG_CTRL);
   wire wr_addr  = reg_wr_i && (reg_addr_i == REG_ADDR);
   wire wr_wdata = reg_wr_i && (reg_addr_i == REG_WDATA);
   wire idle     = (state_q == ST_IDLE);
   wire go_read  = wr_ctrl && reg_wdata_i[CTRL_GO_READ] && idle;
   wire go_write = wr_ctrl && reg_wdata_i[CTRL_GO_WRITE] && idle;
   wire go_reset = wr_ctrl && reg_wdata_i[CTRL_GO_RESET];
   wire word_m   = ctrl_q[CTRL_WORD];
   wire cnt_zero = (cnt_q == 8'h00);
   wire dq5_hit  = (state_q == ST_READ) && ~ready_busy_out_i && flash_dq_i[5];

   // sequencer next state
   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_zero ? 8'h00 : cnt_q - 8'h01;
      if (go_reset) begin
         state_d = ST_RST;
         cnt_d   = RESET_CYC;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (go_read) begin
                  state_d = ST_READ;
                  cnt_d   = ACCESS_CYC;
               end else if (go_write) begin
                  state_d = ST_WRITE;
                  cnt_d   = WRITE_CYC;
               end
            end
            ST_READ: begin
               if (cnt_zero) begin
                  state_d = ST_IDLE;
               end
            end
            ST_WRITE: begin
               if (cnt_zero) begin
                  state_d = ST_WREC;
                  cnt_d   = 8'h01;
               end
            end
            ST_WREC: begin
               if (cnt_zero) begin
                  state_d = ST_IDLE;
               end
            end
            ST_RST: begin
               if (cnt_zero) begin
                  state_d = busy_at_rst_q ? ST_WAIT_RDY : ST_RECOV;
                  cnt_d   = RESET_RECOV_CYC;
               end
            end
            ST_WAIT_RDY: begin
               cnt_d = READY_RECOV_CYC;
               if (ready_busy_out_i) begin
                  state_d = ST_RECOV;
               end
            end
            ST_RECOV: begin
               if (cnt_zero) begin
                  state_d = ST_IDLE;
               end
            end
            default: state_d = ST_IDLE;
         endcase
      end
   end

   // sequencer registers
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state_q <= ST_IDLE;
         cnt_q   <= 8'h00;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
      end
   end

   // software registers
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ctrl_q  <= 6'h00;
         addr_q  <= ADDR_RESET;
         wdata_q <= DATA_RESET;
      end else begin
         if (wr_ctrl) begin
            ctrl_q <= reg_wdata_i[5:0];
         end
         if (wr_addr) begin
            addr_q <= reg_wdata_i;
         end
         if (wr_wdata) begin
            wdata_q <= reg_wdata_i[15:0];
         end
      end
   end

   // capture read data, busy at reset, sticky flags (set wins)
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rdata_q       <= DATA_RESET;
         busy_at_rst_q <= 1'b0;
         timeout_q     <= 1'b0;
         done_q        <= 1'b0;
      end else begin
         if (state_q == ST_READ && cnt_zero) begin
            rdata_q <= word_m ? flash_dq_i : {8'h00, flash_dq_i[7:0]};
         end
         if (go_reset) begin
            busy_at_rst_q <= ~ready_busy_out_i;
         end
         if (dq5_hit) begin
            timeout_q <= 1'b1;
         end else if (go_reset) begin
            timeout_q <= 1'b0;
         end
         if ((state_q != ST_IDLE) && (state_d == ST_IDLE)) begin
            done_q <= 1'b1;
         end else if (go_read || go_write || go_reset) begin
            done_q <= 1'b0;
         end
      end
   end

   // pin drive, width and modes follow a control word written this cycle
   wire [5:0] ctrl_d   = wr_ctrl ? reg_wdata_i[5:0] : ctrl_q;
   wire       word_d   = ctrl_d[CTRL_WORD];
   wire       nx_read  = (state_d == ST_READ);
   wire       nx_write = (state_d == ST_WRITE);
   wire       nx_rst   = (state_d == ST_RST);
   wire       in_read  = (state_q == ST_READ);
   wire       in_write = (state_q == ST_WRITE);
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         flash_ce_n_o    <= 1'b1;
         flash_oe_n_o    <= 1'b1;
         flash_we_n_o    <= 1'b1;
         flash_rst_n_o   <= 1'b0;
         flash_addr_o    <= 19'h0_0000;
         flash_dq_o      <= DATA_RESET;
         flash_dq_oe_n_o <= 16'hFFFF;
         flash_byte_n_o  <= 1'b0;
         a9_hv_o         <= 1'b0;
         rst_hv_o        <= 1'b0;
      end else begin
         flash_ce_n_o   <= ~(nx_read || nx_write);
         flash_oe_n_o   <= ~nx_read;
         flash_we_n_o   <= ~nx_write;
         flash_rst_n_o  <= ~nx_rst;
         flash_byte_n_o <= word_d;
         flash_addr_o   <= word_d ? addr_q[18:0] : addr_q[19:1];
         a9_hv_o        <= ctrl_d[CTRL_ID_MODE];
         rst_hv_o       <= ctrl_d[CTRL_TEMP_UNP] && !nx_rst;
         flash_dq_o     <= word_d ? wdata_q :
                           {7'h00, addr_q[0], wdata_q[7:0]};
         if (state_d == ST_WRITE || state_d == ST_WREC) begin
            flash_dq_oe_n_o <= word_d ? 16'h0000 : 16'h7F00;
         end else if (!word_d && nx_read) begin
            flash_dq_oe_n_o <= 16'h7FFF;       // dq15 driven low; flash_dq_o puts lsb address on dq8
         end else begin
            flash_dq_oe_n_o <= 16'hFFFF;
         end
      end
   end

   // register readback
   wire [19:0] status_w = {13'h0000, ready_busy_out_i, timeout_q,
                           busy_at_rst_q, done_q, in_read, in_write, ~idle};
   wire [19:0] rd_mux = (reg_addr_i == REG_CTRL)   ? {14'h0000, ctrl_q} :
                        (reg_addr_i == REG_ADDR)   ? addr_q :
                        (reg_addr_i == REG_WDATA)  ? {4'h0, wdata_q} :
                        (reg_addr_i == REG_RDATA)  ? {4'h0, rdata_q} :
                        (reg_addr_i == REG_STATUS) ? status_w : 20'h0_0000;
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         reg_rdata_o <= 20'h0_0000;
      end else begin
         reg_rdata_o <= reg_rd_i ? rd_mux : 20'h0_0000;
      end
   end
endmodule

/* flash_dev_model.sv */
module flash_dev_model #(
   parameter logic [7:0]  MAKER = 8'h3c,    // arbitrary value
   parameter logic [15:0] PART  = 16'h1e4b, // arbitrary value
   parameter logic [15:0] PROT  = 16'h0005  // protected sector map
) (
   input  wire logic        clk_i,    // bench clock
   input  wire logic        ce_n_i,   // chip select
   input  wire logic        oe_n_i,   // output gate
   input  wire logic        we_n_i,   // write strobe
   input  wire logic        rst_n_i,  // reset pin
   input  wire logic        byte_n_i, // width select
   input  wire logic        a9_hv_i,  // elevated voltage on a9
   input  wire logic        busy_i,   // bench asks for busy
   input  wire logic [18:0] addr_i,   // address pins
   input  wire logic [15:0] bus_i,    // resolved data pins
   output logic      [15:0] dq_o,     // device data drive
   output logic             ready_o,  // ready pin
   output logic      [19:0] wa_o,     // captured write address
   output logic      [15:0] wd_o      // captured write data
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] last_q = 16'h0000;
   logic [15:0] val;
   logic [15:0] en;
   logic [19:0] ba;
   wire         sel_n = we_n_i | ce_n_i;
   // byte width takes dq15 as lowest address bit
   assign ba = byte_n_i ? {1'b0, addr_i} : {addr_i, bus_i[15]};
   // identification codes by a1:a0, else array data
   assign val = a9_hv_i ? (addr_i[1] ? {15'h0, PROT[addr_i[18:15]]}
      : addr_i[0] ? PART : {8'h00, MAKER}) : ba[15:0] ^ 16'ha5c3;
   // drive only in a read with reset high; floated lines flip
   assign en = (!ce_n_i && !oe_n_i && we_n_i && rst_n_i)
      ? {{8{byte_n_i}}, 8'hff} : 16'h0000;
   assign dq_o = (en & val) | (~en & ~last_q);
   assign ready_o = !busy_i;
   always @(posedge clk_i) last_q <= dq_o;
   // address on later falling edge, data on earlier rising edge
   always @(negedge sel_n) wa_o <= ba;
   always @(posedge sel_n) wd_o <= bus_i;
endmodule

/* flash_host_props.sv */
module flash_host_props (
   input wire logic        clk_i, reset_n_i, reg_rd_i,
   input wire logic [15:0] flash_dq_oe_n_o,
   input wire logic        flash_ce_n_o, flash_oe_n_o, flash_we_n_o,
   input wire logic        flash_rst_n_o, rst_hv_o,
   input wire logic        flash_byte_n_o,
   input wire logic [19:0] reg_rdata_o
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   a_read_we_high:
      assert property (!flash_ce_n_o && !flash_oe_n_o |-> flash_we_n_o)
      else $error("read with write strobe low");
   a_write_gate_high:
      assert property (!flash_we_n_o |-> flash_oe_n_o && !flash_ce_n_o)
      else $error("write without select or with gate low");
   a_no_contention:
      assert property (!flash_oe_n_o |-> (&flash_dq_oe_n_o[14:0]) &&
                       (flash_dq_oe_n_o[15] || !flash_byte_n_o))
      else $error("host drives data while gate low");
   a_rdata_idle_zero:
      assert property (!reg_rd_i |=> reg_rdata_o == 20'h0_0000)
      else $error("read data shown without a read");
   a_data_held:
      assert property ($rose(flash_we_n_o) |-> flash_dq_oe_n_o[7:0] == 8'h00)
      else $error("write data released at strobe rise");
   a_reset_width:
      assert property ($fell(flash_rst_n_o) |-> !flash_rst_n_o [*5])
      else $error("reset pulse too short");
   a_quiet_reset:
      assert property (!flash_rst_n_o |-> flash_ce_n_o && flash_we_n_o)
      else $error("access during reset pulse");
   a_reset_recovery:
      assert property ($rose(flash_rst_n_o) |-> flash_ce_n_o [*2])
      else $error("access before recovery");
   a_temp_unp_reset:
      assert property (rst_hv_o |-> flash_rst_n_o)
      else $error("elevated voltage during reset pulse");
   c_read: cover property (!flash_oe_n_o);
   c_write: cover property ($rose(flash_we_n_o));
   c_reset: cover property ($fell(flash_rst_n_o));
endmodule
bind flash_host flash_host_props flash_host_props_inst (.clk_i, .reset_n_i,
   .reg_rd_i, .flash_dq_oe_n_o, .flash_ce_n_o, .flash_oe_n_o, .flash_we_n_o,
   .flash_rst_n_o, .rst_hv_o, .flash_byte_n_o, .reg_rdata_o);

/* flash_host_tb_top.sv */
module flash_host_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_i = 0, reset_n_i = 0, reg_wr_i = 0, reg_rd_i = 0, busy = 0;
   logic want = 0, pend = 0, ready;
   logic [3:0] reg_addr_i = 4'h0;
   logic [19:0] reg_wdata_i = 20'h0_0000, reg_rdata_o, wa, a;
   logic [18:0] flash_addr_o;
   logic [15:0] flash_dq_o, flash_dq_oe_n_o, dev_dq, bus, wd, e;
   logic flash_ce_n_o, flash_oe_n_o, flash_we_n_o, flash_rst_n_o;
   logic flash_byte_n_o, a9_hv_o, rst_hv_o;
   logic [39:0] exp_q[$], x;
   logic [31:0] rnd = 32'he20a5f0c;
   int fail_count = 0, samples_checked = 0, n;
   // host drives where enabled, device elsewhere
   assign bus = (~flash_dq_oe_n_o & flash_dq_o) | (flash_dq_oe_n_o & dev_dq);
   always #50 clk_i = ~clk_i;
   flash_host flash_host_inst (.clk_i, .reset_n_i, .reg_addr_i, .reg_wdata_i,
      .reg_wr_i, .reg_rd_i, .reg_rdata_o, .flash_addr_o, .flash_dq_o,
      .flash_dq_oe_n_o, .flash_dq_i(bus), .flash_ce_n_o, .flash_oe_n_o,
      .flash_we_n_o, .flash_rst_n_o, .flash_byte_n_o, .a9_hv_o, .rst_hv_o,
      .ready_busy_out_i(ready));
   flash_dev_model flash_dev_model_inst (.clk_i, .ce_n_i(flash_ce_n_o),
      .oe_n_i(flash_oe_n_o), .we_n_i(flash_we_n_o), .rst_n_i(flash_rst_n_o),
      .byte_n_i(flash_byte_n_o), .a9_hv_i(a9_hv_o), .busy_i(busy),
      .addr_i(flash_addr_o), .bus_i(bus), .dq_o(dev_dq), .ready_o(ready),
      .wa_o(wa), .wd_o(wd));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic cmp(input logic [19:0] g, ex, m);
      samples_checked++;
      if ((g & m) !== ex) begin
         fail_count++;
         $display("wrong value at %0t: got %h want %h", $time, g & m, ex);
      end
   endtask
   task automatic wr(input logic [3:0] ad, input logic [19:0] d);
      @(posedge clk_i);
      reg_addr_i <= ad;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge clk_i);
      reg_wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] ad, input logic w,
                     input logic [19:0] ex, m);
      @(posedge clk_i);
      reg_addr_i <= ad;
      reg_rd_i <= 1'b1;
      want <= w;
      if (w) exp_q.push_back({m, ex});
      @(posedge clk_i);
      reg_rd_i <= 1'b0;
   endtask
   task automatic poll();
      n = 0;
      do begin
         rd(4'h4, 1'b0, 20'h0_0000, 20'h0_0000);
         @(negedge clk_i);
         n++;
      end while (reg_rdata_o[3] !== 1'b1 && n < 60);
      if (n == 60) begin
         fail_count++;
         $display("wrong value at %0t: no done", $time);
      end
   endtask
   task automatic go(input logic [19:0] c);
      wr(4'h0, c);
      poll();
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // read results come back in request order
   always @(posedge clk_i) pend <= reg_rd_i && want;
   always @(negedge clk_i) if (pend) begin
      x = exp_q.pop_front();
      cmp(reg_rdata_o, x[19:0], x[39:20]);
   end
   initial begin
      repeat (20000) @(posedge clk_i);
      fail_count++;
      complete_run();
   end
   initial begin
      repeat (20) @(posedge clk_i);
      reset_n_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rnd = lfsr(rnd);
      a = {1'b0, rnd[18:0]};
      e = a[15:0] ^ 16'ha5c3;
      wr(4'h1, a);
      go(20'h0_0009);
      rd(4'h3, 1'b1, {4'h0, e}, 20'h0_ffff);
      rnd = lfsr(rnd);
      a = rnd[19:0];
      e = a[15:0] ^ 16'ha5c3;
      wr(4'h1, a);
      go(20'h0_0001);
      rd(4'h3, 1'b1, {12'h0, e[7:0]}, 20'h0_00ff);
      $display("array reads finished");
      rnd = lfsr(rnd);
      a = {1'b0, rnd[18:0]};
      wr(4'h1, a);
      wr(4'h2, {4'h0, rnd[31:16]});
      go(20'h0_002a);
      cmp(wa, a, 20'hf_ffff);
      cmp({4'h0, wd}, {4'h0, rnd[31:16]}, 20'h0_ffff);
      wr(4'hf, rnd[19:0]);
      $display("write finished");
      for (int i = 0; i < 5; i++) begin
         wr(4'h1, i < 2 ? 20'(i) : {1'b0, 4'(i - 2), 13'h0, 2'b10});
         go(20'h0_0019);
         case (i)
            0: rd(4'h3, 1'b1, 20'h0_003c, 20'h0_00ff);
            1: rd(4'h3, 1'b1, 20'h0_1e4b, 20'h0_ffff);
            3: rd(4'h3, 1'b1, 20'h0_0000, 20'h0_00ff);
            default: rd(4'h3, 1'b1, 20'h0_0001, 20'h0_00ff);
         endcase
      end
      $display("identification finished");
      go(20'h0_002c);
      rd(4'h4, 1'b1, 20'h0_0008, 20'h0_0018);
      busy <= 1'b1;
      wr(4'h0, 20'h0_000c);
      repeat (30) @(posedge clk_i);
      rd(4'h4, 1'b1, 20'h0_0011, 20'h0_0019);
      busy <= 1'b0;
      poll();
      $display("reset finished");
      complete_run();
   end
endmodule
